// ### src/aludq_params.svh
`ifndef ALUDQ_PARAMS_SVH
`define ALUDQ_PARAMS_SVH
// Control field slices
`define ALUDQ_MUX_HI 9
`define ALUDQ_MUX_LO 6
`define ALUDQ_FN_HI 5
`define ALUDQ_FN_LO 2
`define ALUDQ_DQ_HI 1
`define ALUDQ_DQ_LO 0
// Rotator field slices
`define ALUDQ_CI_HI 1
`define ALUDQ_CI_LO 0
`define ALUDQ_SHF_HI 4
`define ALUDQ_SHF_LO 2
// Function codes
`define ALUDQ_FN_SUB 4'h0
`define ALUDQ_FN_SUB_BCD 4'h1
`define ALUDQ_FN_SUB_SR 4'h2
`define ALUDQ_FN_SUB_SL 4'h3
`define ALUDQ_FN_ADD 4'h4
`define ALUDQ_FN_ADD_BCD 4'h5
`define ALUDQ_FN_ADD_SR 4'h6
`define ALUDQ_FN_ADD_SL 4'h7
`define ALUDQ_FN_AND 4'h8
`define ALUDQ_FN_OR 4'h9
`define ALUDQ_FN_AND_SR 4'ha
`define ALUDQ_FN_AND_SL 4'hb
`define ALUDQ_FN_RSUB 4'hc
`define ALUDQ_FN_XOR 4'hd
`define ALUDQ_FN_ANDN 4'he
`define ALUDQ_FN_NAND 4'hf
// Selector values that route the rotator to B
`define ALUDQ_MUX_S_MB 4'h4
`define ALUDQ_MUX_S_XMB 4'h7
`define ALUDQ_MUX_S_D 4'hc
`define ALUDQ_MUX_S_ZERO 4'hd
`define ALUDQ_MUX_S_RB 4'hf
// Hold-register control type selectors
`define ALUDQ_MUX_T2_A 4'h1
`define ALUDQ_MUX_T2_B 4'h3
`define ALUDQ_MUX_T2_C 4'hb
`define ALUDQ_MUX_T3 4'h9
// Rotator codes that modify the rotator latches
`define ALUDQ_ROT_LM0 6'h27
`define ALUDQ_ROT_LM1 6'h2d
`define ALUDQ_ROT_LM2 6'h2f
`define ALUDQ_ROT_LM3 6'h3b
`define ALUDQ_ROT_LM4 6'h3d
`define ALUDQ_ROT_LM5 6'h3f
// Carry-in select codes
`define ALUDQ_CI_ZERO 2'h0
`define ALUDQ_CI_SAVED 2'h1
`define ALUDQ_CI_ONE 2'h2
`define ALUDQ_CI_PSW 2'h3
// Shift-in select codes
`define ALUDQ_SHF_ZERO 3'h0
`define ALUDQ_SHF_ONE 3'h1
`define ALUDQ_SHF_SHIFT 3'h2
`define ALUDQ_SHF_ROT 3'h3
`define ALUDQ_SHF_A0Q1 3'h4
`define ALUDQ_SHF_A1Q0 3'h5
`define ALUDQ_SHF_WB30 3'h6
`define ALUDQ_SHF_PSW 3'h7
// Decimal digit limits
`define ALUDQ_BCD_MAX 5'h09
`define ALUDQ_BCD_FIX 5'h06
// Register map and bits
`define ALUDQ_ADDR_D 3'h0
`define ALUDQ_ADDR_Q 3'h1
`define ALUDQ_ADDR_STAT 3'h2
`define ALUDQ_ADDR_CTRL 3'h3
`define ALUDQ_STAT_CARRY 0
`define ALUDQ_STAT_OD 1
`define ALUDQ_CTRL_HOLD 0
`endif

// ### src/aludq_pkg.sv
package aludq_pkg;
    // Microword fields this block consumes
    typedef struct packed {
        logic [5:0] rotator_field;
        logic [9:0] ctl;
    } aludq_uword_t;
    // Hold-register control type
    typedef enum logic [2:0] {
        DQ_T1 = 3'b001,
        DQ_T2 = 3'b010,
        DQ_T3 = 3'b100
    } aludq_dq_t;
    // Shift direction of ALU result or Q
    typedef enum logic [2:0] {
        SD_NONE = 3'b001,
        SD_RIGHT = 3'b010,
        SD_LEFT = 3'b100
    } aludq_sdir_t;
endpackage

// ### src/aludq_bcd.sv
`timescale 1ns/1ps
`include "aludq_params.svh"
// Decimal add or subtract, one digit per 4-bit slice
module aludq_bcd (
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic ci,
    input wire logic sub,
    output logic [31:0] res,
    output logic cout
);
    // Ripple through eight digits, correcting each one
    always_comb begin
        logic [4:0] t;
        logic c;
        t = 5'h00;
        c = ci;
        res = 32'h0;
        for (int i = 0; i < 8; i++) begin
            if (sub) begin
                // Borrow out when the raw digit went negative
                t = {1'b0, a[i*4 +: 4]} - {1'b0, b[i*4 +: 4]} - {4'h0, c};
                c = t[4];
                if (c) begin
                    t = t - `ALUDQ_BCD_FIX;
                end
            end else begin
                // Carry out when the raw digit passes nine
                t = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
                c = (t > `ALUDQ_BCD_MAX);
                if (c) begin
                    t = t + `ALUDQ_BCD_FIX;
                end
            end
            res[i*4 +: 4] = t[3:0];
        end
        cout = c;
    end
endmodule

// ### src/aludq_core.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`include "aludq_params.svh"
// Summary of operation
// [RULE1] Codes 0-7: subtract or add, BCD, SR, SL
// [RULE2] Codes 8-F: logical and reverse-subtract functions
// [RULE3] Output-disabled codes depend on selector 9/D
// [RULE4] Carry-in from bits 59:58 normally
// [RULE5] Carry-in: zero, saved carry, one, status carry
// [RULE6] Saved carry records add/subtract carry
// [RULE7] Rotator selector forces carry-in zero
// [RULE8] Latch-modifying rotator codes force carry-in zero
// [RULE9] Shift-ins from bits 62:60 normally
// [RULE10] Shift-in select fixed encodings
// [RULE11] Codes 010/011 use both shift directions
// [RULE12] Rotator or latch codes force shift-ins zero
// [RULE13] Q bit 31 shift-in undefined when Q loads
// [RULE14] BCD codes adjust every digit to 0-9
// [RULE15] D loads writeback select, feeds A
// [RULE16] Q shifts or loads, feeds B
// [RULE17] Low two bits form typed DQ control
// [RULE18] DQ control sets loads and Q shift
// [RULE19] Only add, subtract, AND shift results
// [RULE20] Selector value chooses DQ type
// [RULE21] Writeback picks ALU or B operand
// [RULE22] Output-disabled function suppresses bus drive
// [RULE23] 010/011 chain ALU and Q as 64 bits
// [RULE24] All state updates per edge, reset clears
module aludq_core (
    input wire logic sys_clk,
    input wire logic reset,
    input wire aludq_pkg::aludq_uword_t uword,
    input wire logic special_function,
    input wire logic special_q_from_a,
    input wire logic wb_select_b,
    input wire logic [31:0] a_operand,
    input wire logic [31:0] b_operand,
    input wire logic psw_carry,
    input wire logic write_bus_bit30,
    input wire logic write_bus_bit31,
    input wire logic [2:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [31:0] d_reg_out,
    output logic [31:0] q_reg_out,
    output logic [31:0] write_bus_out,
    output logic write_bus_drive
);
    // Selector values that route the rotator into B
    function automatic logic rot_path(input logic [3:0] m);
        rot_path = (m == `ALUDQ_MUX_S_MB) || (m == `ALUDQ_MUX_S_XMB) ||
                   (m == `ALUDQ_MUX_S_D) || (m == `ALUDQ_MUX_S_ZERO) ||
                   (m == `ALUDQ_MUX_S_RB);
    endfunction

    // Rotator codes that touch the rotator latches
    function automatic logic latch_mod(input logic [5:0] r);
        latch_mod = (r == `ALUDQ_ROT_LM0) || (r == `ALUDQ_ROT_LM1) ||
                    (r == `ALUDQ_ROT_LM2) || (r == `ALUDQ_ROT_LM3) ||
                    (r == `ALUDQ_ROT_LM4) || (r == `ALUDQ_ROT_LM5);
    endfunction

    logic [3:0] mux_f; // Operand selector
    logic [3:0] fn_f; // Function code
    logic [1:0] dq_f; // Hold-register control bits
    logic [1:0] ci_f; // Carry-in select
    logic [2:0] shf_f; // Shift-in select
    logic force_zero; // Rotator owns the upper microword bits
    logic alu_ci; // ALU carry input
    logic saved_carry_r; // Saved carry flag
    logic hold_r; // Software freeze of D, Q and ALU saved-carry updates
    logic od_r; // Last cycle had output disabled
    logic [31:0] d_r; // Result holding register
    logic [31:0] q_r; // Shift holding register
    logic [31:0] write_bus_r; // Registered write bus data
    logic drive_r; // Registered write bus enable
    logic [31:0] rdata_r; // Read data for the cycle after a read

    assign mux_f = uword.ctl[`ALUDQ_MUX_HI:`ALUDQ_MUX_LO];
    assign fn_f = uword.ctl[`ALUDQ_FN_HI:`ALUDQ_FN_LO];
    assign dq_f = uword.ctl[`ALUDQ_DQ_HI:`ALUDQ_DQ_LO];
    assign ci_f = uword.rotator_field[`ALUDQ_CI_HI:`ALUDQ_CI_LO];
    assign shf_f = uword.rotator_field[`ALUDQ_SHF_HI:`ALUDQ_SHF_LO];
    assign force_zero = rot_path(mux_f) || latch_mod(uword.rotator_field); // [RULE7] [RULE8] [RULE12]

    // Carry-in selection
    always_comb begin
        if (force_zero) begin
            alu_ci = 1'b0; // [RULE7] [RULE8]
        end else begin
            unique case (ci_f) // [RULE4] [RULE5]
                `ALUDQ_CI_ZERO: alu_ci = 1'b0;
                `ALUDQ_CI_SAVED: alu_ci = saved_carry_r;
                `ALUDQ_CI_ONE: alu_ci = 1'b1;
                `ALUDQ_CI_PSW: alu_ci = psw_carry;
            endcase
        end
    end
    // Output-disabled interpretation of the function code
    logic od;
    always_comb begin
        unique case (fn_f) // [RULE3]
            `ALUDQ_FN_AND, `ALUDQ_FN_RSUB: od = (mux_f == `ALUDQ_MUX_T3);
            `ALUDQ_FN_AND_SR, `ALUDQ_FN_AND_SL: od = (mux_f == `ALUDQ_MUX_S_ZERO);
            `ALUDQ_FN_OR, `ALUDQ_FN_XOR: od = (mux_f == `ALUDQ_MUX_T3) ||
                (mux_f == `ALUDQ_MUX_S_ZERO);
            default: od = 1'b0;
        endcase
    end
    // Raw arithmetic results, 33 bits to keep carry and borrow
    logic [32:0] sub_ab, add_ab, sub_ba;
    assign sub_ab = {1'b0, a_operand} - {1'b0, b_operand} - {32'h0, alu_ci};
    assign add_ab = {1'b0, a_operand} + {1'b0, b_operand} + {32'h0, alu_ci};
    assign sub_ba = {1'b0, b_operand} - {1'b0, a_operand} - {32'h0, alu_ci};

    // Decimal adjust path for the BCD codes
    logic [31:0] bcd_res;
    logic bcd_cout;
    aludq_bcd u_bcd (
        .a(a_operand),
        .b(b_operand),
        .ci(alu_ci),
        .sub(fn_f == `ALUDQ_FN_SUB_BCD),
        .res(bcd_res),
        .cout(bcd_cout)
    );

    // Function decode: unshifted value, carry and shift direction
    logic [31:0] raw;
    logic arith;
    logic carry_out;
    aludq_pkg::aludq_sdir_t alu_dir;
    always_comb begin
        raw = a_operand & b_operand;
        carry_out = 1'b0;
        alu_dir = aludq_pkg::SD_NONE;
        // Add, subtract and reverse subtract report a carry
        arith = (fn_f < `ALUDQ_FN_AND) || (fn_f == `ALUDQ_FN_RSUB);
        unique case (fn_f) // [RULE1] [RULE2] [RULE19]
            `ALUDQ_FN_SUB, `ALUDQ_FN_SUB_SR, `ALUDQ_FN_SUB_SL: {carry_out, raw} = sub_ab;
            `ALUDQ_FN_SUB_BCD, `ALUDQ_FN_ADD_BCD: begin
                {carry_out, raw} = {bcd_cout, bcd_res}; // [RULE14]
            end
            `ALUDQ_FN_ADD, `ALUDQ_FN_ADD_SR, `ALUDQ_FN_ADD_SL: {carry_out, raw} = add_ab;
            `ALUDQ_FN_AND, `ALUDQ_FN_AND_SR, `ALUDQ_FN_AND_SL: raw = a_operand & b_operand;
            `ALUDQ_FN_OR: raw = a_operand | b_operand;
            `ALUDQ_FN_RSUB: {carry_out, raw} = sub_ba;
            `ALUDQ_FN_XOR: raw = a_operand ^ b_operand;
            `ALUDQ_FN_ANDN: raw = a_operand & ~b_operand;
            `ALUDQ_FN_NAND: raw = ~a_operand & b_operand;
        endcase
        // Only the three shiftable groups carry a direction
        if ((fn_f == `ALUDQ_FN_SUB_SR) || (fn_f == `ALUDQ_FN_ADD_SR) ||
            (fn_f == `ALUDQ_FN_AND_SR)) begin
            alu_dir = aludq_pkg::SD_RIGHT; // [RULE19]
        end else if ((fn_f == `ALUDQ_FN_SUB_SL) || (fn_f == `ALUDQ_FN_ADD_SL) ||
                     (fn_f == `ALUDQ_FN_AND_SL)) begin
            alu_dir = aludq_pkg::SD_LEFT; // [RULE19]
        end
    end

    // Hold-register control: type, loads and Q shift direction
    aludq_pkg::aludq_dq_t dq_type;
    logic load_q, load_d;
    aludq_pkg::aludq_sdir_t q_dir;
    always_comb begin
        if ((mux_f == `ALUDQ_MUX_T2_A) || (mux_f == `ALUDQ_MUX_T2_B) ||
            (mux_f == `ALUDQ_MUX_T2_C)) begin
            dq_type = aludq_pkg::DQ_T2; // [RULE20]
        end else if (mux_f == `ALUDQ_MUX_T3) begin
            dq_type = aludq_pkg::DQ_T3; // [RULE20]
        end else begin
            dq_type = aludq_pkg::DQ_T1; // [RULE20]
        end
        load_q = 1'b0;
        load_d = 1'b0;
        q_dir = aludq_pkg::SD_NONE;
        if (special_function) begin
            // Special functions use the low bits as plain load enables
            {load_d, load_q} = dq_f; // [RULE17]
        end else begin
            unique case (dq_type) // [RULE17] [RULE18]
                aludq_pkg::DQ_T1: {load_d, load_q} = dq_f;
                aludq_pkg::DQ_T2: begin
                    q_dir = dq_f[0] ? aludq_pkg::SD_RIGHT : aludq_pkg::SD_LEFT;
                    load_d = dq_f[1];
                end
                aludq_pkg::DQ_T3: begin
                    // Upper two codes are undefined and do nothing
                    if (!dq_f[1]) begin
                        q_dir = dq_f[0] ? aludq_pkg::SD_RIGHT : aludq_pkg::SD_LEFT;
                        load_d = 1'b1;
                    end
                end
            endcase
        end
    end
    // Shift-in selection for ALU and Q
    logic alu_shin, q_shin;
    logic alu_lost, q_lost;
    always_comb begin
        // Bits that leave each register during its shift
        alu_lost = (alu_dir == aludq_pkg::SD_LEFT) ? raw[31] : raw[0];
        q_lost = (q_dir == aludq_pkg::SD_LEFT) ? q_r[31] : q_r[0];
        alu_shin = 1'b0;
        q_shin = 1'b0;
        if (!force_zero) begin
            unique case (shf_f) // [RULE9] [RULE10]
                `ALUDQ_SHF_ZERO: {alu_shin, q_shin} = 2'h0;
                `ALUDQ_SHF_ONE: {alu_shin, q_shin} = 2'h3;
                `ALUDQ_SHF_SHIFT, `ALUDQ_SHF_ROT: begin
                    if (alu_dir == aludq_pkg::SD_NONE) begin
                        // Q alone: wrap on itself or take bus bit 31
                        q_shin = shf_f[0] ? q_lost : write_bus_bit31; // [RULE11] [RULE23]
                    end else if (q_dir == aludq_pkg::SD_NONE) begin
                        // ALU alone: wrap or take Q bit 31
                        alu_shin = shf_f[0] ? alu_lost : q_r[31]; // [RULE11] [RULE13]
                    end else if (alu_dir == aludq_pkg::SD_RIGHT &&
                                 q_dir == aludq_pkg::SD_RIGHT) begin
                        // ALU sits above Q in the chain
                        q_shin = alu_lost; // [RULE23]
                        alu_shin = shf_f[0] ? q_lost : 1'b0;
                    end else begin
                        // Q feeds the ALU end of the chain
                        alu_shin = q_lost; // [RULE23]
                        q_shin = shf_f[0] ? alu_lost : 1'b0;
                    end
                end
                `ALUDQ_SHF_A0Q1: {alu_shin, q_shin} = 2'h1;
                `ALUDQ_SHF_A1Q0: {alu_shin, q_shin} = 2'h2;
                `ALUDQ_SHF_WB30: {alu_shin, q_shin} = {2{write_bus_bit30}};
                `ALUDQ_SHF_PSW: {alu_shin, q_shin} = {2{psw_carry}};
            endcase
        end
    end
    // Final ALU output and writeback select
    logic [31:0] alu_out, wmux;
    always_comb begin
        unique case (alu_dir)
            aludq_pkg::SD_RIGHT: alu_out = {alu_shin, raw[31:1]};
            aludq_pkg::SD_LEFT: alu_out = {raw[30:0], alu_shin};
            aludq_pkg::SD_NONE: alu_out = raw;
        endcase
        wmux = wb_select_b ? b_operand : alu_out; // [RULE21]
    end
    // Result holding register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            d_r <= 32'h0; // [RULE24]
        end else if (load_d && !hold_r) begin
            d_r <= wmux; // [RULE15]
        end
    end

    // Shift holding register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q_r <= 32'h0; // [RULE24]
        end else if (!hold_r) begin
            if (q_dir == aludq_pkg::SD_LEFT) begin
                q_r <= {q_r[30:0], q_shin}; // [RULE16]
            end else if (q_dir == aludq_pkg::SD_RIGHT) begin
                q_r <= {q_shin, q_r[31:1]}; // [RULE16]
            end else if (load_q) begin
                q_r <= special_q_from_a ? a_operand : wmux; // [RULE16]
            end
        end
    end

    // Saved carry: ALU update wins over a software write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            saved_carry_r <= 1'b0; // [RULE24]
        end else if (arith && !hold_r) begin
            saved_carry_r <= carry_out; // [RULE6]
        end else if (reg_wr && reg_addr == `ALUDQ_ADDR_STAT) begin
            saved_carry_r <= reg_wdata[`ALUDQ_STAT_CARRY];
        end
    end

    // Write bus data and enable, one cycle behind the operation
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            write_bus_r <= 32'h0;
            drive_r <= 1'b0;
            od_r <= 1'b0;
        end else begin
            write_bus_r <= wmux;
            drive_r <= !od; // [RULE22]
            od_r <= od;
        end
    end

    // Control register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hold_r <= 1'b0;
        end else if (reg_wr && reg_addr == `ALUDQ_ADDR_CTRL) begin
            hold_r <= reg_wdata[`ALUDQ_CTRL_HOLD];
        end
    end

    // Read port: data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset || !reg_rd) begin
            rdata_r <= 32'h0;
        end else begin
            unique case (reg_addr)
                `ALUDQ_ADDR_D: rdata_r <= d_r;
                `ALUDQ_ADDR_Q: rdata_r <= q_r;
                `ALUDQ_ADDR_STAT: rdata_r <= {30'h0, od_r, saved_carry_r};
                `ALUDQ_ADDR_CTRL: rdata_r <= {31'h0, hold_r};
                default: rdata_r <= 32'h0;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign d_reg_out = d_r;
    assign q_reg_out = q_r;
    assign write_bus_out = write_bus_r;
    assign write_bus_drive = drive_r;

    // Checks on the datapath
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // Type-three decode: shift Q left and load D together
    sequence dq3_left_s;
        mux_f == `ALUDQ_MUX_T3 && dq_f == 2'h0 && !special_function && !hold_r;
    endsequence
    sequence dq3_done_s;
        q_reg_out[31:1] == $past(q_r[30:0]) && d_reg_out == $past(wmux);
    endsequence
    add_result_a: assert property ( // [RULE1]
        fn_f == `ALUDQ_FN_ADD && !wb_select_b |=>
        write_bus_out == $past(a_operand + b_operand + {31'h0, alu_ci}))
        else $error("add result wrong");
    carry_zero_a: assert property ( // [RULE7]
        force_zero && fn_f == `ALUDQ_FN_ADD && !wb_select_b |=>
        write_bus_out == $past(a_operand + b_operand))
        else $error("carry-in not forced to zero");
    carry_one_a: assert property ( // [RULE5]
        !force_zero && ci_f == `ALUDQ_CI_ONE && fn_f == `ALUDQ_FN_SUB &&
        !wb_select_b |=> write_bus_out == $past(a_operand - b_operand - 32'h1))
        else $error("carry-in one not applied");
    drive_off_a: assert property ( // [RULE22]
        (fn_f == `ALUDQ_FN_XOR || fn_f == `ALUDQ_FN_OR) &&
        (mux_f == `ALUDQ_MUX_T3 || mux_f == `ALUDQ_MUX_S_ZERO) |=> !write_bus_drive)
        else $error("write bus driven for disabled output");
    d_load_a: assert property ( // [RULE15]
        load_d && !hold_r |=> d_reg_out == $past(wmux))
        else $error("result register did not load");
    carry_save_a: assert property ( // [RULE6]
        fn_f == `ALUDQ_FN_ADD && !hold_r |=> saved_carry_r == $past(add_ab[32]))
        else $error("saved carry not updated");
    shin_zero_a: assert property ( // [RULE12]
        force_zero && fn_f == `ALUDQ_FN_ADD_SR && !wb_select_b |=> !write_bus_out[31])
        else $error("shift-in not forced to zero");
    shin_one_a: assert property ( // [RULE10]
        !force_zero && shf_f == `ALUDQ_SHF_ONE && fn_f == `ALUDQ_FN_AND_SL &&
        !wb_select_b |=> write_bus_out[0])
        else $error("shift-in one not applied");
    dq3_pair_a: assert property ( // [RULE20]
        dq3_left_s |=> dq3_done_s)
        else $error("type-three control wrong");
endmodule

// ### dv/aludq_useq.sv
`timescale 1ns/1ps
// Microsequencer stand-in: issues the next microword at each clock edge
module aludq_useq (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [9:0] next_ctl,
    input wire logic [5:0] next_rot,
    output aludq_pkg::aludq_uword_t uword
);
    // Control store output; idle word is a plain AND with no register loads
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            uword <= '{rotator_field: 6'h00, ctl: 10'h020};
        end else begin
            uword <= '{rotator_field: next_rot, ctl: next_ctl};
        end
    end
endmodule

// ### dv/alu_function_shift_dq_control_test.sv
`timescale 1ns/1ps
// Self-checking bench for the ALU control and D/Q holding logic
module alu_function_shift_dq_control_test;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] next_ctl = 10'h020;
    logic [5:0] next_rot = 6'h00;
    aludq_pkg::aludq_uword_t uword;
    logic special_function = 1'b0, special_q_from_a = 1'b0, wb_select_b = 1'b0;
    logic [31:0] a_operand = 32'h0, b_operand = 32'h0, reg_wdata = 32'h0;
    logic psw_carry = 1'b1, write_bus_bit30 = 1'b1, write_bus_bit31 = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, write_bus_drive;
    logic [31:0] reg_rdata, d_reg_out, q_reg_out, write_bus_out, qx;
    // Scenario tables
    logic [3:0] mx [5] = '{4'h4, 4'h7, 4'hc, 4'hd, 4'hf};
    logic [5:0] rc [6] = '{6'h27, 6'h2d, 6'h2f, 6'h3b, 6'h3d, 6'h3f};
    logic [5:0] sr [9] = '{6'h00, 6'h04, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h3d, 6'h08, 6'h0c};
    logic [8:0] sa = 9'h03a, sq = 9'h1b6;
    logic [31:0] ex [8] = '{32'h18, 32'h7e, 32'h8000000c, 32'h31, 32'h1e, 32'h66, 32'h24, 32'h42};
    logic [7:0] oc [9] = '{8'h98, 8'h9c, 8'hda, 8'hdb, 8'h99, 8'hdd, 8'h9a, 8'hd8, 8'h09};
    logic [8:0] odx = 9'h1c0;
    int err_count = 0;
    int check_count = 0;
    int i;

    // Free-running 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    aludq_useq seq_u (.sys_clk, .reset, .next_ctl, .next_rot, .uword);
    aludq_core dut_u (.sys_clk, .reset, .uword, .special_function, .special_q_from_a,
        .wb_select_b, .a_operand, .b_operand, .psw_carry, .write_bus_bit30,
        .write_bus_bit31, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .d_reg_out, .q_reg_out, .write_bus_out, .write_bus_drive);

    // Compare one value and count it
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic results;
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One microinstruction: word one cycle ahead, operands beside its execution
    task automatic op(input logic [9:0] c, input logic [5:0] r, input logic [31:0] x,
        input logic [31:0] y);
        @(posedge sys_clk);
        next_ctl <= c;
        next_rot <= r;
        @(posedge sys_clk);
        next_ctl <= 10'h020;
        next_rot <= 6'h00;
        a_operand <= x;
        b_operand <= y;
        @(posedge sys_clk);
        #1;
    endtask

    // One register access; read data is sampled in the cycle after the strobe
    task automatic rw(input logic w, input logic [2:0] ad, input logic [31:0] dt);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    // Guard against a hung run
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        results;
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        rw(1'b0, 3'h2, 32'h0);
        cmp(reg_rdata, 32'h0);
        cmp(d_reg_out | q_reg_out | write_bus_out, 32'h0);
        // Every carry-in select code on an add
        for (i = 0; i < 4; i++) begin
            op({4'h0, 4'h4, 2'h3}, {4'h0, i[1:0]}, 32'h1, 32'h2);
            cmp(d_reg_out, (i < 2) ? 32'h3 : 32'h4);
        end
        cmp(q_reg_out, 32'h4);
        cmp({31'h0, write_bus_drive}, 32'h1);
        // Borrow is saved and then used as carry-in
        op({4'h0, 4'h0, 2'h2}, 6'h02, 32'h0, 32'h1);
        cmp(d_reg_out, 32'hfffffffe);
        rw(1'b0, 3'h2, 32'h0);
        cmp(reg_rdata, 32'h1);
        op({4'h0, 4'h4, 2'h2}, 6'h01, 32'h1, 32'h2);
        cmp(d_reg_out, 32'h4);
        // Rotator selects and latch codes force carry-in to zero
        foreach (mx[k]) begin
            op({mx[k], 4'h4, 2'h0}, 6'h02, 32'h1, 32'h2);
            cmp(write_bus_out, 32'h3);
        end
        foreach (rc[k]) begin
            op({4'h0, 4'h4, 2'h0}, rc[k], 32'h1, 32'h2);
            cmp(write_bus_out, 32'h3);
        end
        // Shift-in codes with ALU and Q both shifting right
        op({4'h0, 4'h4, 2'h1}, 6'h00, 32'h2, 32'h0);
        qx = 32'h2;
        foreach (sr[k]) begin
            op({4'h1, 4'h6, 2'h1}, sr[k], 32'h3, 32'h0);
            qx = {sq[k], qx[31:1]};
            cmp(write_bus_out, {sa[k], 31'h1});
            cmp(q_reg_out, qx);
        end
        // Logical and reverse-subtract functions
        for (i = 8; i < 16; i++) begin
            op({4'h0, i[3:0], 2'h2}, 6'h04, 32'h3c, 32'h5a);
            cmp(d_reg_out, ex[i-8]);
        end
        // Output-disabled decoding against the selector
        foreach (oc[k]) begin
            op({oc[k], 2'h0}, 6'h00, 32'h3c, 32'h5a);
            cmp({31'h0, write_bus_drive}, {31'h0, odx[k]});
        end
        // Special function: plain loads, writeback from B, Q from A
        @(posedge sys_clk);
        special_function <= 1'b1;
        special_q_from_a <= 1'b1;
        wb_select_b <= 1'b1;
        op({4'h9, 4'h4, 2'h3}, 6'h00, 32'h11, 32'h22);
        cmp(d_reg_out, 32'h22);
        cmp(q_reg_out, 32'h11);
        cmp(write_bus_out, 32'h22);
        @(posedge sys_clk);
        special_function <= 1'b0;
        special_q_from_a <= 1'b0;
        wb_select_b <= 1'b0;
        // Decimal add and subtract
        op({4'h0, 4'h5, 2'h2}, 6'h00, 32'h19, 32'h01);
        cmp(d_reg_out, 32'h20);
        op({4'h0, 4'h1, 2'h2}, 6'h00, 32'h20, 32'h01);
        cmp(d_reg_out, 32'h19);
        // Unmapped read, read-only write, hold freezes D
        rw(1'b0, 3'h5, 32'h0);
        cmp(reg_rdata, 32'h0);
        rw(1'b1, 3'h0, 32'hffffffff);
        rw(1'b0, 3'h0, 32'h0);
        cmp(reg_rdata, 32'h19);
        rw(1'b1, 3'h3, 32'h1);
        op({4'h0, 4'h4, 2'h2}, 6'h00, 32'h1, 32'h1);
        cmp(d_reg_out, 32'h19);
        rw(1'b1, 3'h3, 32'h0);
        results;
    end
endmodule
